// [shared/tdccfg_pkg.sv]
// Package of offsets, field positions, reset values and timing for the configuration bank
package tdccfg_pkg;

    // Register geometry
    localparam int unsigned REG_W         = 16;
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned NUM_REGS      = 4;

    // Register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_HDR_TRL  = 4'h0;
    localparam logic [ADDR_W-1:0] IDX_MODE     = 4'h1;
    localparam logic [ADDR_W-1:0] IDX_CH12     = 4'h2;
    localparam logic [ADDR_W-1:0] IDX_CH34     = 4'h3;
    localparam logic [ADDR_W-1:0] IDX_STATUS   = 4'h4;

    // Reset value shared by every register
    localparam logic [REG_W-1:0] REG_RESET    = 16'h0000;

    // Register 0 fields
    localparam int unsigned HDR_EN_LSB    = 8;
    localparam int unsigned TRL_EN_LSB    = 0;
    localparam int unsigned NUM_CH        = 8;

    // Register 1 fields
    localparam int unsigned MODE_HIRES    = 15;
    localparam int unsigned MODE_HIT32    = 14;
    localparam int unsigned MODE_LETRA    = 13;
    localparam int unsigned CORE_ADJ_LSB  = 11;
    localparam int unsigned CORE_ADJ_W    = 2;
    localparam int unsigned MODE_RSV_HI   = 10;
    localparam int unsigned MODE_RSV_LO   = 9;
    localparam int unsigned TRIG_SPD_LSB  = 7;
    localparam int unsigned TRIG_SPD_W    = 2;
    localparam int unsigned MODE_XFER     = 6;
    localparam int unsigned MODE_STOP_OFF = 5;
    localparam int unsigned PROC_SPD_LSB  = 1;
    localparam int unsigned PROC_SPD_W    = 4;
    localparam int unsigned MODE_DAC_GO   = 0;

    // Channel pair fields (registers 2 and 3)
    localparam int unsigned PAIR_HI_FALL  = 15;
    localparam int unsigned PAIR_HI_RISE  = 14;
    localparam int unsigned PAIR_HI_ADJ   = 8;
    localparam int unsigned PAIR_LO_FALL  = 7;
    localparam int unsigned PAIR_LO_RISE  = 6;
    localparam int unsigned PAIR_LO_ADJ   = 0;
    localparam int unsigned ADJ_W         = 6;

    // Status register bits
    localparam int unsigned STAT_DAC_BUSY = 0;
    localparam int unsigned STAT_SAFE_ERR = 1;

    // DAC load pulse time and its cycle count at 250 MHz
    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned DAC_PULSE_NS  = 40;
    localparam int unsigned DAC_PULSE_CYC = (DAC_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned DAC_CNT_W     = 4;

    // Bus answer for unmapped reads
    localparam logic [31:0] UNMAPPED_RD   = 32'h0000_0000;

endpackage : tdccfg_pkg

// [design/tdccfg_regfile.sv]
// Small storage array holding the configuration words, registered read port
module tdccfg_regfile #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 4,
    parameter int unsigned AW    = 2
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             clk_en_i,
    // Write port
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_addr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    input  wire logic [WIDTH-1:0] wr_mask_i,
    // Read port
    input  wire logic [AW-1:0]    rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o,
    // Whole contents, for decode
    output logic      [WIDTH-1:0] words_o [DEPTH]
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rd;
    } tdccfg_rf_s;

    tdccfg_rf_s st_q;
    tdccfg_rf_s st_d;

    // Masked write; read data taken from the pre-write contents
    always_comb begin
        st_d    = st_q;
        st_d.rd = st_q.mem[rd_addr_i];
        if (wr_en_i) begin
            st_d.mem[wr_addr_i] = (st_q.mem[wr_addr_i] & ~wr_mask_i) | (wr_data_i & wr_mask_i);
        end
    end

    // All words clear to zero at reset
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= '0;
        end else if (clk_en_i) begin
            st_q <= st_d;
        end
    end

    assign rd_data_o = st_q.rd;

    // Expose each word for field decode
    for (genvar g = 0; g < DEPTH; g++) begin : g_words
        assign words_o[g] = st_q.mem[g];
    end

endmodule : tdccfg_regfile

// [design/tdccfg_regs.sv]
// Configuration register bank of the time-measurement chip, Avalon-MM slave
//
// What this block does
// - Register 0 high byte: header enables ch8..1
// - Register 0 low byte: trailer enables ch8..1
// - Register 1 bit 15 selects high resolution
// - Bit 14 hit mode, bit 13 edge-pair mode
// - Bits 12:11 two-bit core adjust field
// - Bits 10:9 stored, without any effect
// - Bits 8:7 trigger processing speed field
// - Bit 6 output-to-interface buffer transfer rate
// - Bit 5 disables all stop inputs
// - Bits 4:1 result processing speed field
// - Setting bit 0 starts DAC transfer unless one is still busy
// - Register 2 edge enables, channels 2 and 1
// - Register 2 bits 13:8 channel 2 delay
// - Register 2 bits 5:0 channel 1 delay
// - Register 3 mirrors layout for channels 4,3
//
// The Avalon-MM register port is this design's own decision.
module tdccfg_regs (
    // Clock, reset and enable
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        clk_en_i,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic      [1:0]  avs_response_o,
    // DAC loader handshake
    input  wire logic        dac_load_done_i,
    output logic             dac_load_start_o,
    // Per-channel output word enables
    output logic      [7:0]  header_en_o,
    output logic      [7:0]  trailer_en_o,
    // Operating mode
    output logic             high_res_o,
    output logic             hit32_mode_o,
    output logic             lead_trail_mode_o,
    output logic      [1:0]  core_adjust_o,
    output logic      [1:0]  trig_speed_o,
    output logic             xfer_rate_o,
    output logic      [3:0]  proc_speed_o,
    output logic             stop_inputs_off_o,
    // Channel edge enables and delays, channels 1..4
    output logic      [3:0]  fall_en_o,
    output logic      [3:0]  rise_en_o,
    output logic      [23:0] delay_adj_o
);

    localparam int unsigned W = tdccfg_pkg::REG_W;
    localparam int unsigned N = tdccfg_pkg::NUM_REGS;

    // Bus phase: idle, one cycle for the registered read port to settle, then done
    typedef enum logic [1:0] {
        TDCCFG_IDLE = 2'b00,
        TDCCFG_WAIT = 2'b01,
        TDCCFG_DONE = 2'b10
    } tdccfg_phase_e;

    typedef struct packed {
        tdccfg_phase_e                          phase;
        logic                                   busy;
        logic [tdccfg_pkg::DAC_CNT_W-1:0]       dac_cnt;
        logic                                   dac_go;
        logic                                   dac_busy;
        logic [31:0]                            rdata;
        logic                                   wait_n;
        logic [1:0]                             resp;
        logic [7:0]                             hdr;
        logic [7:0]                             trl;
        logic                                   hires;
        logic                                   hit32;
        logic                                   letra;
        logic [1:0]                             core;
        logic [1:0]                             trig;
        logic                                   xfer;
        logic [3:0]                             proc;
        logic                                   stop_off;
        logic [3:0]                             fall;
        logic [3:0]                             rise;
        logic [23:0]                            dly;
    } tdccfg_st_s;

    tdccfg_st_s st_q;
    tdccfg_st_s st_d;

    logic [W-1:0] words [N];
    logic [W-1:0] rf_rdata;
    logic         mapped;
    logic         is_status;
    logic         wr_fire;
    logic [W-1:0] wr_mask;
    logic [W-1:0] status_word;

    // Indices 0..3 are storage, 4 is the read-only status word
    assign mapped    = (avs_address_i <= tdccfg_pkg::IDX_STATUS);
    assign is_status = (avs_address_i == tdccfg_pkg::IDX_STATUS);

    // Writes land on the first cycle of a mapped storage access
    assign wr_fire = avs_write_i && (st_q.phase == TDCCFG_IDLE) && mapped && !is_status;

    // Low two byte lanes cover the sixteen stored bits; upper lanes ignored
    assign wr_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    // Status shows the block's own state
    assign status_word = W'({st_q.dac_busy, 1'b0} >> 1)
        | (W'(st_q.dac_busy) << tdccfg_pkg::STAT_DAC_BUSY)
        | (W'(|{st_q.core, st_q.trig, st_q.xfer, st_q.proc}) << tdccfg_pkg::STAT_SAFE_ERR);

    // Storage; every word resets to zero and reads back as written
    tdccfg_regfile #(
        .WIDTH (W),
        .DEPTH (N),
        .AW    (2)
    ) u_rf (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .clk_en_i   (clk_en_i),
        .wr_en_i    (wr_fire),
        .wr_addr_i  (avs_address_i[1:0]),
        .wr_data_i  (avs_writedata_i[W-1:0]),
        .wr_mask_i  (wr_mask),
        .rd_addr_i  (avs_address_i[1:0]),
        .rd_data_o  (rf_rdata),
        .words_o    (words)
    );

    // Bus sequencing, field decode and DAC start pulse
    always_comb begin
        st_d        = st_q;
        st_d.wait_n = 1'b0;

        unique case (st_q.phase)
            TDCCFG_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    st_d.phase = TDCCFG_WAIT;
                end
            end
            TDCCFG_WAIT: begin
                // Read data is registered here; waitrequest drops next cycle
                st_d.phase  = TDCCFG_DONE;
                st_d.wait_n = 1'b1;
                st_d.resp   = mapped ? 2'b00 : 2'b11;
                if (!mapped) begin
                    st_d.rdata = tdccfg_pkg::UNMAPPED_RD;
                end else if (is_status) begin
                    st_d.rdata = {16'h0000, status_word};
                end else begin
                    st_d.rdata = {16'h0000, rf_rdata};
                end
            end
            TDCCFG_DONE: begin
                // Master releases on this edge; return to idle
                st_d.phase = TDCCFG_IDLE;
                st_d.resp  = 2'b00;
            end
            default: begin
                st_d.phase = TDCCFG_IDLE;
            end
        endcase

        // Register 0 decode, channel n at bit offset n-1
        st_d.hdr = words[0][tdccfg_pkg::HDR_EN_LSB +: tdccfg_pkg::NUM_CH];
        st_d.trl = words[0][tdccfg_pkg::TRL_EN_LSB +: tdccfg_pkg::NUM_CH];

        // Register 1 decode
        st_d.hires    = words[1][tdccfg_pkg::MODE_HIRES];
        st_d.hit32    = words[1][tdccfg_pkg::MODE_HIT32];
        st_d.letra    = words[1][tdccfg_pkg::MODE_LETRA];
        st_d.core     = words[1][tdccfg_pkg::CORE_ADJ_LSB +: tdccfg_pkg::CORE_ADJ_W];
        // Bits 10:9 are only stored; nothing decodes them
        st_d.trig     = words[1][tdccfg_pkg::TRIG_SPD_LSB +: tdccfg_pkg::TRIG_SPD_W];
        st_d.xfer     = words[1][tdccfg_pkg::MODE_XFER];
        st_d.stop_off = words[1][tdccfg_pkg::MODE_STOP_OFF];
        st_d.proc     = words[1][tdccfg_pkg::PROC_SPD_LSB +: tdccfg_pkg::PROC_SPD_W];

        // Channel pair decode: reg 2 holds ch2/ch1, reg 3 holds ch4/ch3
        for (int p = 0; p < 2; p++) begin
            st_d.fall[2*p]   = words[2+p][tdccfg_pkg::PAIR_LO_FALL];
            st_d.rise[2*p]   = words[2+p][tdccfg_pkg::PAIR_LO_RISE];
            st_d.fall[2*p+1] = words[2+p][tdccfg_pkg::PAIR_HI_FALL];
            st_d.rise[2*p+1] = words[2+p][tdccfg_pkg::PAIR_HI_RISE];
            st_d.dly[12*p +: 6]     = words[2+p][tdccfg_pkg::PAIR_LO_ADJ +: tdccfg_pkg::ADJ_W];
            st_d.dly[12*p+6 +: 6]   = words[2+p][tdccfg_pkg::PAIR_HI_ADJ +: tdccfg_pkg::ADJ_W];
        end

        // DAC start: a mode write with bit 0 set launches one transfer unless dac_busy is set
        st_d.dac_go = 1'b0;
        if (wr_fire && (avs_address_i == tdccfg_pkg::IDX_MODE) && avs_byteenable_i[0]
            && avs_writedata_i[tdccfg_pkg::MODE_DAC_GO] && !st_q.dac_busy) begin
            st_d.dac_busy = 1'b1;
            st_d.dac_cnt  = tdccfg_pkg::DAC_CNT_W'(tdccfg_pkg::DAC_PULSE_CYC);
        end
        if (st_q.dac_cnt != '0) begin
            st_d.dac_go  = 1'b1;
            st_d.dac_cnt = st_q.dac_cnt - 1'b1;
        end
        // Busy holds until the loader reports done, at least past the pulse
        if (st_q.dac_busy && (st_q.dac_cnt == '0) && !st_q.dac_go && dac_load_done_i) begin
            st_d.dac_busy = 1'b0;
        end
    end

    // Single state register; freezes while the clock enable is low
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q       <= '0;
            st_q.phase <= TDCCFG_IDLE;
        end else if (clk_en_i) begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign avs_readdata_o    = st_q.rdata;
    assign avs_waitrequest_o = !st_q.wait_n;
    assign avs_response_o    = st_q.resp;
    assign dac_load_start_o  = st_q.dac_go;
    assign header_en_o       = st_q.hdr;
    assign trailer_en_o      = st_q.trl;
    assign high_res_o        = st_q.hires;
    assign hit32_mode_o      = st_q.hit32;
    assign lead_trail_mode_o = st_q.letra;
    assign core_adjust_o     = st_q.core;
    assign trig_speed_o      = st_q.trig;
    assign xfer_rate_o       = st_q.xfer;
    assign proc_speed_o      = st_q.proc;
    assign stop_inputs_off_o = st_q.stop_off;
    assign fall_en_o         = st_q.fall;
    assign rise_en_o         = st_q.rise;
    assign delay_adj_o       = st_q.dly;

endmodule : tdccfg_regs

// [sim/tdccfg_dac_model.sv]
// Behavioural DAC loader answering load pulses with a done level
module tdccfg_dac_model (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    // Loader handshake and pace select
    input  wire logic start_i,
    input  wire logic slow_i,
    output logic      done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] cnt_q;

    // Done drops for the pulse and a settling time after it; slow pace outlasts the pulse
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q  <= 6'h00;
            done_o <= 1'b1;
        end else if (start_i) begin
            cnt_q  <= slow_i ? 6'h28 : 6'h02;
            done_o <= 1'b0;
        end else if (cnt_q != 6'h00) begin
            cnt_q <= cnt_q - 6'h01;
        end else begin
            done_o <= 1'b1;
        end
    end
endmodule : tdccfg_dac_model

// [sim/tdccfg_regs_chk.sv]
// Checker on the configuration bank ports
module tdccfg_regs_chk (
    // Clock and reset
    input wire logic        core_clk_i,
    input wire logic        rstn_i,
    input wire logic        clk_en_i,
    // Bus
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [1:0]  avs_response_o,
    // DAC load pulse and decoded fields
    input wire logic        dac_load_start_o,
    input wire logic [7:0]  header_en_o,
    input wire logic [7:0]  trailer_en_o,
    input wire logic        high_res_o,
    input wire logic        hit32_mode_o,
    input wire logic        lead_trail_mode_o,
    input wire logic [1:0]  core_adjust_o,
    input wire logic [1:0]  trig_speed_o,
    input wire logic        xfer_rate_o,
    input wire logic [3:0]  proc_speed_o,
    input wire logic        stop_inputs_off_o,
    input wire logic [3:0]  fall_en_o,
    input wire logic [3:0]  rise_en_o,
    input wire logic [23:0] delay_adj_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk_i); endclocking
    // Frozen cycles stretch every timing below, so they are left out
    default disable iff (!rstn_i || !clk_en_i);
    // Full-word write start; outputs lag it by two edges
    wire logic [15:0] wd = avs_writedata_i[15:0];
    wire logic        wstart = avs_write_i && avs_byteenable_i[1:0] == 2'h3;

    property p_hdr; $rose(wstart) && avs_address_i == 4'h0 |-> ##2
        {header_en_o, trailer_en_o} == $past(wd, 2); endproperty
    a_hdr: assert property (p_hdr) else $error("header or trailer enables wrong");
    property p_mode; $rose(wstart) && avs_address_i == 4'h1 |-> ##2
        {high_res_o, hit32_mode_o, lead_trail_mode_o, core_adjust_o, trig_speed_o, xfer_rate_o, stop_inputs_off_o,
         proc_speed_o} == {$past(wd[15:11], 2), $past(wd[8:1], 2)}; endproperty
    a_mode: assert property (p_mode) else $error("mode wrong");
    property p_ch12; $rose(wstart) && avs_address_i == 4'h2 |-> ##2 {fall_en_o[1], rise_en_o[1], delay_adj_o[11:6],
        fall_en_o[0], rise_en_o[0], delay_adj_o[5:0]} == $past(wd, 2); endproperty
    a_ch12: assert property (p_ch12) else $error("channel 1 or 2 setup wrong");
    property p_ch34; $rose(wstart) && avs_address_i == 4'h3 |-> ##2 {fall_en_o[3], rise_en_o[3], delay_adj_o[23:18],
        fall_en_o[2], rise_en_o[2], delay_adj_o[17:12]} == $past(wd, 2); endproperty
    a_ch34: assert property (p_ch34) else $error("channel 3 or 4 setup wrong");
    // Bus answer timing and codes
    property p_wait3; $rose(avs_read_i || avs_write_i) |->
        avs_waitrequest_o ##1 avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
    a_wait3: assert property (p_wait3) else $error("answer not in third cycle");
    property p_wait1; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    a_wait1: assert property (p_wait1) else $error("answer longer than one cycle");
    property p_resp; !avs_waitrequest_o |-> avs_response_o == (avs_address_i > 4'h4 ? 2'h3 : 2'h0)
        && avs_readdata_o[31:16] == 16'h0000; endproperty
    a_resp: assert property (p_resp) else $error("response code or upper data wrong");
    // Load pulse is ten cycles and only follows a start write
    property p_pulse; $rose(dac_load_start_o) |=>
        dac_load_start_o[*8] ##1 dac_load_start_o ##1 !dac_load_start_o; endproperty
    a_pulse: assert property (p_pulse) else $error("load pulse length wrong");
    property p_cause; $rose(dac_load_start_o) |->
        $past(avs_write_i && avs_address_i == 4'h1 && avs_writedata_i[0], 2); endproperty
    a_cause: assert property (p_cause) else $error("load pulse without start write");

    c_dac: cover property ($rose(dac_load_start_o));
    c_bad: cover property (!avs_waitrequest_o && avs_response_o == 2'h3);
    c_rd: cover property (avs_read_i && !avs_waitrequest_o);
endmodule : tdccfg_regs_chk

// [sim/tdccfg_regs_tb.sv]
// Testbench of the configuration bank with DAC loader model
`define CHK(nm, ex, got) begin total_checks++; \
    if ((got) !== (ex)) begin err_count++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end

module tdccfg_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i, rstn_i, clk_en_i, avs_read_i, avs_write_i, dac_load_done_i, dac_load_start_o, slow;
    logic high_res_o, hit32_mode_o, lead_trail_mode_o, xfer_rate_o, stop_inputs_off_o, avs_waitrequest_o;
    logic [3:0] avs_address_i, avs_byteenable_i, proc_speed_o, fall_en_o, rise_en_o;
    logic [31:0] avs_writedata_i, avs_readdata_o, rdat;
    logic [1:0] avs_response_o, core_adjust_o, trig_speed_o, rresp;
    logic [7:0] header_en_o, trailer_en_o;
    logic [23:0] delay_adj_o;
    logic frz_done;
    logic [15:0] sh [4];
    int err_count, total_checks, pulses;

    // Decoded fields gathered back into register layout
    wire logic [4:0]  mode_w = {high_res_o, hit32_mode_o, lead_trail_mode_o, core_adjust_o};
    wire logic [7:0]  spd_w  = {trig_speed_o, xfer_rate_o, stop_inputs_off_o, proc_speed_o};
    wire logic [15:0] ch12_w = {fall_en_o[1], rise_en_o[1], delay_adj_o[11:6],
                                fall_en_o[0], rise_en_o[0], delay_adj_o[5:0]};
    wire logic [15:0] ch34_w = {fall_en_o[3], rise_en_o[3], delay_adj_o[23:18],
                                fall_en_o[2], rise_en_o[2], delay_adj_o[17:12]};

    tdccfg_regs i_dut (.core_clk_i, .rstn_i, .clk_en_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o,
        .dac_load_done_i, .dac_load_start_o, .header_en_o, .trailer_en_o, .high_res_o, .hit32_mode_o,
        .lead_trail_mode_o, .core_adjust_o, .trig_speed_o, .xfer_rate_o, .proc_speed_o, .stop_inputs_off_o,
        .fall_en_o, .rise_en_o, .delay_adj_o);
    tdccfg_dac_model i_dac (.core_clk_i, .rstn_i, .start_i(dac_load_start_o), .slow_i(slow),
        .done_o(dac_load_done_i));

    // Clock and load pulse counter
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    always @(posedge dac_load_start_o) pulses++;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // One bus access; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge core_clk_i);
        avs_address_i    <= a;
        avs_write_i      <= w;
        avs_read_i       <= !w;
        avs_writedata_i  <= d;
        avs_byteenable_i <= b;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        `CHK("waitrequest", 1'b0, avs_waitrequest_o)
        rdat = avs_readdata_o;
        rresp = avs_response_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        if (w && a < 4'h4 && b[0]) sh[a[1:0]][7:0] = d[7:0];
        if (w && a < 4'h4 && b[1]) sh[a[1:0]][15:8] = d[15:8];
    endtask : bus

    // Read back every storage register and compare decoded outputs with the shadow
    task automatic chk_all(input string t);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 4'(i), 32'h0, 4'h3);
            `CHK("readback", {16'h0000, sh[i]}, rdat)
        end
        `CHK("header_en", sh[0][15:8], header_en_o)
        `CHK("trailer_en", sh[0][7:0], trailer_en_o)
        `CHK("mode", sh[1][15:11], mode_w)
        `CHK("speeds", sh[1][8:1], spd_w)
        `CHK("ch12", sh[2], ch12_w)
        `CHK("ch34", sh[3], ch34_w)
        $display("test %s done", t);
    endtask : chk_all

    // Main sequence
    initial begin
        {rstn_i, avs_read_i, avs_write_i, slow} = 4'h0;
        clk_en_i = 1'b1;
        avs_address_i = 4'h0;
        avs_byteenable_i = 4'h0;
        avs_writedata_i = 32'h0;
        sh = '{default: 16'h0000};
        repeat (8) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        chk_all("reset");
        // Patterns avoid bit 0 of the mode word; upper lanes carry junk
        foreach (sh[i]) bus(1'b1, 4'(i), {16'hDEAD, 16'hA5C3 ^ 16'(i)}, 4'hF);
        chk_all("pattern_a");
        foreach (sh[i]) bus(1'b1, 4'(i), {16'hBEEF, 16'h5A3D ^ 16'(i)}, 4'hF);
        chk_all("pattern_b");
        bus(1'b1, 4'h2, 32'h0000_FFFF, 4'h1);
        bus(1'b1, 4'h3, 32'h0000_0000, 4'h2);
        chk_all("lanes");
        // Unmapped and read-only places; safety field still set
        bus(1'b1, 4'h9, 32'h0000_FFFF, 4'h3);
        bus(1'b0, 4'h9, 32'h0, 4'h3);
        `CHK("unmapped", 34'h3_0000_0000, {rresp, rdat})
        bus(1'b1, 4'h4, 32'h0000_FFFF, 4'h3);
        bus(1'b0, 4'h4, 32'h0, 4'h3);
        `CHK("status", 34'h0_0000_0002, {rresp, rdat})
        chk_all("unmapped");
        // Prompt loader, then slow loader with a start write while busy
        bus(1'b1, 4'h1, 32'h0000_0001, 4'h3);
        bus(1'b0, 4'h4, 32'h0, 4'h3);
        `CHK("busy", 32'h0000_0001, rdat)
        repeat (40) @(posedge core_clk_i);
        bus(1'b0, 4'h4, 32'h0, 4'h3);
        `CHK("idle", 32'h0000_0000, rdat)
        slow <= 1'b1;
        bus(1'b1, 4'h1, 32'h0000_0001, 4'h3);
        bus(1'b1, 4'h1, 32'h0000_0001, 4'h3);
        repeat (30) @(posedge core_clk_i);
        bus(1'b0, 4'h4, 32'h0, 4'h3);
        `CHK("slow_busy", 32'h0000_0001, rdat)
        repeat (40) @(posedge core_clk_i);
        `CHK("pulses", 2, pulses)
        chk_all("dac");
        // Clock enable low holds a write unanswered and unstored
        clk_en_i <= 1'b0;
        frz_done = 1'b0;
        fork
            begin
                bus(1'b1, 4'h0, 32'h0000_3C96, 4'h3);
                frz_done = 1'b1;
            end
            begin
                repeat (12) @(posedge core_clk_i);
                `CHK("frozen", 1'b0, frz_done)
                clk_en_i <= 1'b1;
            end
        join
        chk_all("freeze");
        // Reset in mid-run clears everything
        rstn_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        sh = '{default: 16'h0000};
        chk_all("rereset");
        tally_and_finish();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #80000;
        err_count++;
        tally_and_finish();
    end
endmodule : tdccfg_regs_tb

bind tdccfg_regs tdccfg_regs_chk i_chk (.core_clk_i, .rstn_i, .clk_en_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o,
    .dac_load_start_o, .header_en_o, .trailer_en_o, .high_res_o, .hit32_mode_o, .lead_trail_mode_o,
    .core_adjust_o, .trig_speed_o, .xfer_rate_o, .proc_speed_o, .stop_inputs_off_o, .fall_en_o, .rise_en_o,
    .delay_adj_o);
